/* rsl_pcs_model.sv */
// Purpose: Far-side PCS model that feeds receive columns into the block
// Assumes: Bench picks the column kind; one column per clock
// Notes:   kind 0 idle, 1 local seq, 2 remote seq, 3 invalid column

module rsl_pcs_model import rsl_pkg::*; (
  // Clock
  input wire logic hclk,
  // Column request from the bench
  input wire logic [1:0] kind,
  input wire logic hi,
  // Receive column to the block
  output logic rx_col_valid,
  output logic [63:0] rxd,
  output logic [7:0] rxc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] seq_w;

  // ------------------------------------------------------------
  // Column generation
  // ------------------------------------------------------------
  // Sequence word: code in lane 0, fault value in lane 3
  assign seq_w = {(kind == 2'h2) ? SEQ_REMOTE : SEQ_LOCAL, 16'h0000, CH_SEQ};

  // Known values before the first edge
  initial begin
    rx_col_valid = 1'b0;
    rxd = IDLE_COL;
    rxc = IDLE_CTL;
  end

  // Invalid columns invert the last value each clock, so stale data reappears every second column
  always @(posedge hclk) begin
    rx_col_valid <= (kind != 2'h3);
    case (kind)
      2'h0: begin
        rxd <= IDLE_COL;
        rxc <= IDLE_CTL;
      end
      2'h3: begin
        rxd <= ~rxd;
        rxc <= ~rxc;
      end
      default: begin
        rxd <= hi ? {seq_w, IDLE_COL[31:0]} : {IDLE_COL[63:32], seq_w};
        rxc <= hi ? 8'h1f : 8'hf1;
      end
    endcase
  end
endmodule // rsl_pcs_model

/* rsl_pkg.sv */
// Purpose: Shared constants and types for the link fault signalling block
// Assumes: 64-bit columns with 8 control bits, one bit per byte lane
// Notes:   Register indices are word indices; byte address is index * 4

package rsl_pkg;

  // ----------------------------------------------------------------
  // Register map (word indices)
  // ----------------------------------------------------------------
  localparam logic [11:0] CFG_IDX = 12'h405;
  localparam logic [11:0] IST_IDX = 12'h406;
  localparam logic [11:0] ICLR_IDX = 12'h407;
  localparam logic [11:0] IEN_IDX = 12'h408;
  localparam logic [11:0] LIVE_IDX = 12'h409;

  // Control register fields and reset value
  localparam int CFG_GEN_BIT = 0;
  localparam int CFG_UNI_BIT = 1;
  localparam logic [1:0] CFG_RST = 2'h0;

  // Interrupt status bit positions
  localparam int IRQ_LF_SET = 0;
  localparam int IRQ_RF_SET = 1;
  localparam int IRQ_LF_CLR = 2;
  localparam int IRQ_RF_CLR = 3;
  localparam int IRQ_W = 4;
  localparam logic [3:0] IRQ_RST = 4'h0;

  // ----------------------------------------------------------------
  // Fault detector timing
  // ----------------------------------------------------------------
  localparam logic [7:0] COL_LIMIT = 8'h80;
  localparam logic [2:0] SEQ_NEED = 3'h4;

  // ----------------------------------------------------------------
  // Column codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_SEQ = 8'h9c;
  localparam logic [7:0] SEQ_LOCAL = 8'h01;
  localparam logic [7:0] SEQ_REMOTE = 8'h02;
  localparam logic [63:0] RF_COL = {2{32'h0200009c}};
  localparam logic [7:0] RF_CTL = 8'h11;
  localparam logic [63:0] IDLE_COL = {8{8'h07}};
  localparam logic [7:0] IDLE_CTL = 8'hff;

  // Receive link fault state, one-hot
  typedef enum logic [2:0] {
    FLT_OK = 3'b001,
    FLT_LOCAL = 3'b010,
    FLT_REMOTE = 3'b100
  } rsl_flt_t;

endpackage

/* rsl_seq_det.sv */
// Purpose: Recognise a fault sequence ordered set in one half of a column
// Assumes: Sequence sits in a four-lane group starting at lane LANE
// Notes:   Purely combinational; other sequence values are ignored

module rsl_seq_det import rsl_pkg::*; #(
  parameter int LANE = 0
) (
  // Column from the receive path
  input wire logic [63:0] col_d,
  input wire logic [7:0] col_c,
  // Classification
  output logic is_local,
  output logic is_remote
);

  logic hdr_ok;

  // Control byte in the first lane only, zero data in lanes one and two
  assign hdr_ok = (col_c[LANE +: 4] == 4'h1) &&
                  (col_d[LANE*8 +: 8] == CH_SEQ) &&
                  (col_d[LANE*8+8 +: 16] == 16'h0000);
  assign is_local = hdr_ok && (col_d[LANE*8+24 +: 8] == SEQ_LOCAL);
  assign is_remote = hdr_ok && (col_d[LANE*8+24 +: 8] == SEQ_REMOTE);

endmodule // rsl_seq_det

/* rsl_top.sv */
// Purpose: Link fault monitor and transmit fault insertion, AHB-Lite regs
// Assumes: Receive and transmit columns both on hclk, one column a cycle
// Notes:   Reads take one wait state, writes none; response always OKAY

module rsl_top import rsl_pkg::*; #(
  parameter logic [7:0] COLS = COL_LIMIT,
  parameter logic [2:0] NEED = SEQ_NEED
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Receive columns from the PCS
  input wire logic rx_col_valid,
  input wire logic [63:0] rxd,
  input wire logic [7:0] rxc,
  // Transmit columns from the MAC
  input wire logic [63:0] txd,
  input wire logic [7:0] txc,
  // Transmit columns to the PCS
  output logic [63:0] line_txd,
  output logic [7:0] line_txc,
  // Status and configuration
  output logic local_fault_status,
  output logic remote_fault_status,
  output logic unidirectional_en,
  output logic link_fault_gen_en,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    rsl_flt_t link;
    logic last_rem;
    logic have_last;
    logic [2:0] seq_cnt;
    logic [7:0] col_cnt;
    logic [1:0] cfg;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] ien;
    logic wr_pend;
    logic [11:0] wr_idx;
    logic rd_pend;
    logic [11:0] rd_idx;
    logic [31:0] rdata;
    logic [63:0] line_d;
    logic [7:0] line_c;
  } rsl_state_t;

  localparam rsl_state_t ST_RST = '{
    link: FLT_OK, last_rem: 1'b0, have_last: 1'b0, seq_cnt: 3'h0,
    col_cnt: 8'h00, cfg: CFG_RST, ist: IRQ_RST, ien: IRQ_RST,
    wr_pend: 1'b0, wr_idx: 12'h000, rd_pend: 1'b0, rd_idx: 12'h000,
    rdata: 32'h0000_0000, line_d: IDLE_COL, line_c: IDLE_CTL};

  rsl_state_t s_q;
  rsl_state_t s_d;

  logic loc0, rem0, loc4, rem4;
  logic col_seq, col_rem, match, accept, tx_idle;
  logic [2:0] cnt_n;
  logic [IRQ_W-1:0] ev, clr_mask;

  // ----------------------------------------------------------------
  // Sequence detectors, one per half column
  // ----------------------------------------------------------------
  rsl_seq_det #(.LANE(0)) u_det_lo (
    .col_d(rxd),
    .col_c(rxc),
    .is_local(loc0),
    .is_remote(rem0)
  );

  rsl_seq_det #(.LANE(4)) u_det_hi (
    .col_d(rxd),
    .col_c(rxc),
    .is_local(loc4),
    .is_remote(rem4)
  );

  // Lower half wins when both halves carry a sequence
  assign col_seq = loc0 | rem0 | loc4 | rem4;
  assign col_rem = (loc0 | rem0) ? rem0 : rem4;

  // Word-sized transfers at any address; those above the low 16 KB decode to no register
  assign accept = hsel && htrans[1] && hready && (hsize == 3'h2);
  assign tx_idle = (txc == IDLE_CTL) && (txd == IDLE_COL);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    clr_mask = '0;
    match = 1'b0;
    cnt_n = 3'h0;

    // Write data phase; writes never wait
    s_d.wr_pend = 1'b0;
    if (s_q.wr_pend) begin
      case (s_q.wr_idx)
        CFG_IDX: s_d.cfg = hwdata[1:0];
        ICLR_IDX: clr_mask = hwdata[IRQ_W-1:0];
        IEN_IDX: s_d.ien = hwdata[IRQ_W-1:0];
        default: ;
      endcase
    end

    // Read data is fetched in the wait cycle, after any prior write
    s_d.rd_pend = 1'b0;
    if (s_q.rd_pend) begin
      case (s_q.rd_idx)
        CFG_IDX: s_d.rdata = {30'h0, s_q.cfg};
        IST_IDX: s_d.rdata = {28'h0, s_q.ist};
        IEN_IDX: s_d.rdata = {28'h0, s_q.ien};
        LIVE_IDX: s_d.rdata = {30'h0, s_q.link == FLT_REMOTE,
                               s_q.link == FLT_LOCAL};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    // Address phase capture
    if (accept) begin
      if (haddr[31:14] != 18'h0) begin
        s_d.wr_idx = 12'hfff;
        s_d.rd_idx = 12'hfff;
      end else begin
        s_d.wr_idx = haddr[13:2];
        s_d.rd_idx = haddr[13:2];
      end
      s_d.wr_pend = hwrite;
      s_d.rd_pend = !hwrite;
    end

    // Receive fault detection, one step per valid column
    if (rx_col_valid) begin
      if (col_seq) begin
        // Like sequence close enough to the last one extends the run
        match = s_q.have_last && (s_q.last_rem == col_rem) &&
                (s_q.col_cnt < COLS);
        if (!match) begin
          cnt_n = 3'h1;
        end else if (s_q.seq_cnt == NEED) begin
          cnt_n = s_q.seq_cnt;
        end else begin
          cnt_n = s_q.seq_cnt + 3'h1;
        end
        s_d.seq_cnt = cnt_n;
        s_d.col_cnt = 8'h00;
        s_d.last_rem = col_rem;
        s_d.have_last = 1'b1;
        if (cnt_n == NEED) begin
          s_d.link = col_rem ? FLT_REMOTE : FLT_LOCAL;
        end
      end else if (s_q.col_cnt != COLS) begin
        // Saturate once the quiet span has expired
        s_d.col_cnt = s_q.col_cnt + 8'h01;
        if (s_q.col_cnt == COLS - 8'h01) begin
          s_d.link = FLT_OK;
          s_d.seq_cnt = 3'h0;
          s_d.have_last = 1'b0;
        end
      end
    end

    // Interrupt events: flags entering and leaving a fault
    ev = '0;
    ev[IRQ_LF_SET] = (s_d.link == FLT_LOCAL) && (s_q.link != FLT_LOCAL);
    ev[IRQ_RF_SET] = (s_d.link == FLT_REMOTE) && (s_q.link != FLT_REMOTE);
    ev[IRQ_LF_CLR] = (s_d.link != FLT_LOCAL) && (s_q.link == FLT_LOCAL);
    ev[IRQ_RF_CLR] = (s_d.link != FLT_REMOTE) && (s_q.link == FLT_REMOTE);
    // A new event beats a clear in the same cycle
    s_d.ist = (s_q.ist & ~clr_mask) | ev;

    // Transmit path; fault state is the one already registered
    s_d.line_d = txd;
    s_d.line_c = txc;
    if (s_q.cfg[CFG_GEN_BIT]) begin
      if (!s_q.cfg[CFG_UNI_BIT]) begin
        if (s_q.link == FLT_LOCAL) begin
          s_d.line_d = RF_COL;
          s_d.line_c = RF_CTL;
        end else if (s_q.link == FLT_REMOTE) begin
          s_d.line_d = IDLE_COL;
          s_d.line_c = IDLE_CTL;
        end
      end else if (s_q.link == FLT_LOCAL && tx_idle) begin
        // Only gap columns are replaced so frames keep flowing
        s_d.line_d = RF_COL;
        s_d.line_c = RF_CTL;
      end
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout = !s_q.rd_pend;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign line_txd = s_q.line_d;
  assign line_txc = s_q.line_c;
  // Live flags, never gated by the control register
  assign local_fault_status = (s_q.link == FLT_LOCAL);
  assign remote_fault_status = (s_q.link == FLT_REMOTE);
  assign unidirectional_en = s_q.cfg[CFG_UNI_BIT];
  assign link_fault_gen_en = s_q.cfg[CFG_GEN_BIT];
  assign irq = |(s_q.ist & s_q.ien);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic cfg_wr;
  assign cfg_wr = s_q.wr_pend && (s_q.wr_idx == CFG_IDX);

  sequence s_local_col;
    rx_col_valid && col_seq && !col_rem;
  endsequence

  sequence s_bidir_local;
    link_fault_gen_en && !unidirectional_en && local_fault_status;
  endsequence

  AST_GEN_ONLY_BY_WRITE: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(link_fault_gen_en) |-> $past(cfg_wr) && $past(hwdata[0]))
    else $error("fault generation enabled without a control write");

  AST_BIDIR_LOCAL: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_bidir_local |=> line_txc == RF_CTL && line_txd == RF_COL)
    else $error("bidirectional local fault did not send remote fault");

  AST_BIDIR_REMOTE: assert property (
    @(posedge hclk) disable iff (!hresetn)
    link_fault_gen_en && !unidirectional_en && remote_fault_status
    |=> line_txc == IDLE_CTL && line_txd == IDLE_COL)
    else $error("bidirectional remote fault did not send idles");

  AST_UNI_FRAMES_FLOW: assert property (
    @(posedge hclk) disable iff (!hresetn)
    link_fault_gen_en && unidirectional_en && !tx_idle
    |=> line_txd == $past(txd) && line_txc == $past(txc))
    else $error("unidirectional mode altered a frame column");

  AST_UNI_GAP_FAULT: assert property (
    @(posedge hclk) disable iff (!hresetn)
    link_fault_gen_en && unidirectional_en && local_fault_status && tx_idle
    |=> line_txc == RF_CTL && line_txd == RF_COL)
    else $error("unidirectional gap lacks remote fault sequence");

  AST_FOUR_LOCAL: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_local_col [*4] |=> local_fault_status && !remote_fault_status)
    else $error("four local sequences did not set local fault");

  AST_QUIET_CLEARS: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rx_col_valid && !col_seq && s_q.col_cnt == COLS - 8'h01
    |=> !local_fault_status && !remote_fault_status)
    else $error("quiet span did not return state to OK");

  AST_PASS_WHEN_OFF: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !link_fault_gen_en |=> line_txd == $past(txd) && line_txc == $past(txc))
    else $error("columns altered while signalling disabled");

  AST_CFG_FOLLOW: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cfg_wr |=> unidirectional_en == $past(hwdata[1]) &&
               link_fault_gen_en == $past(hwdata[0]))
    else $error("enable outputs do not follow control write");

  AST_READ_WAIT: assert property (
    @(posedge hclk) disable iff (!hresetn)
    accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");

  sequence s_remote_col;
    rx_col_valid && col_seq && col_rem;
  endsequence

  AST_FOUR_REMOTE: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_remote_col [*4] |=> remote_fault_status && !local_fault_status)
    else $error("four remote sequences did not set remote fault");

  // Flag must survive every quiet column short of the full span
  AST_QUIET_HOLDS: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rx_col_valid && !col_seq && local_fault_status &&
    s_q.col_cnt < COLS - 8'h01 |=> local_fault_status)
    else $error("local fault cleared before the quiet span ended");

  AST_FIRST_SEQ_WAITS: assert property (
    @(posedge hclk) disable iff (!hresetn)
    rx_col_valid && col_seq && !s_q.have_last
    |=> $stable(local_fault_status) && $stable(remote_fault_status))
    else $error("a lone fault sequence changed the fault state");

  // Invalid columns neither count towards nor break a span
  AST_INVALID_HOLDS: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !rx_col_valid
    |=> $stable(local_fault_status) && $stable(remote_fault_status))
    else $error("an invalid column changed the fault state");

  AST_UNI_REMOTE_PASS: assert property (
    @(posedge hclk) disable iff (!hresetn)
    link_fault_gen_en && unidirectional_en && remote_fault_status
    |=> line_txd == $past(txd) && line_txc == $past(txc))
    else $error("unidirectional remote fault altered a column");

  AST_IRQ_ON_LOCAL: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(local_fault_status) && s_q.ien[IRQ_LF_SET] |-> irq)
    else $error("entering local fault did not raise the interrupt");

endmodule // rsl_top

/* tb_top.sv */
// Purpose: Self-checking bench for the link fault block
// Assumes: Single AHB-Lite slave, hready looped from hreadyout
// Notes:   COLS shortened to 8 so the clear spans stay short

module tb_top import rsl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, hi;
  logic rx_col_valid, unidirectional_en, link_fault_gen_en;
  logic local_fault_status, remote_fault_status;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [1:0] htrans, kind, obs;
  logic [2:0] hsize;
  logic [63:0] rxd, txd, line_txd;
  logic [7:0] rxc, txc, line_txc;
  logic [71:0] exp_q[$];
  int err_count, n_checks;

  // ------------------------------------------------------------
  // Design, far side and clock
  // ------------------------------------------------------------
  assign hready = hreadyout;
  rsl_top #(.COLS(8'h08), .NEED(3'h4)) dut_u (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
    .hrdata, .rx_col_valid, .rxd, .rxc, .txd, .txc, .line_txd, .line_txc,
    .local_fault_status, .remote_fault_status, .unidirectional_en,
    .link_fault_gen_en, .irq);
  rsl_pcs_model pcs_u (.hclk, .kind, .hi, .rx_col_valid, .rxd, .rxc);
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task test_done;
    if (err_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [71:0] seen, input logic [71:0] e);
    n_checks++;
    if (seen !== e) begin
      err_count++;
      $display("mismatch %s exp %h seen %h", nm, e, seen);
    end
  endtask
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Bounded wait for an edge that samples ready high
  task wait_rdy;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      err_count++;
      test_done;
    end
  endtask
  task bus(input logic w, input logic [11:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {18'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    obs <= w ? 2'h0 : 2'h1;
    wait_rdy;
    obs <= 2'h0;
  endtask
  task rd(input logic [11:0] idx, input logic [31:0] e);
    exp_q.push_back({40'h0, e});
    bus(1'b0, idx, 32'h0);
  endtask
  // One trailing invalid column keeps kind from two writes in one step
  task cols(input logic [1:0] k, input int n, input logic h);
    kind <= k;
    hi <= h;
    repeat (n) @(posedge hclk);
    kind <= 2'h3;
    @(posedge hclk);
  endtask
  // Random data column; m 0 passes, 1 fault column, 2 idle column
  task rtx(input logic [1:0] m);
    logic [63:0] d;
    seed = lfsr(seed);
    d = {seed, ~seed};
    exp_q.push_back(m == 2'h1 ? {RF_CTL, RF_COL} :
      m == 2'h2 ? {IDLE_CTL, IDLE_COL} : {8'h00, d});
    txd <= d;
    txc <= 8'h00;
    @(posedge hclk) obs <= 2'h2;
    @(posedge hclk) obs <= 2'h0;
  endtask
  task st(input logic [4:0] e);
    exp_q.push_back({67'h0, e});
    @(posedge hclk) obs <= 2'h3;
    @(posedge hclk) obs <= 2'h0;
  endtask

  // ------------------------------------------------------------
  // Output watcher: oldest note against what appears
  // ------------------------------------------------------------
  always @(posedge hclk) begin
    if (obs == 2'h1 && hreadyout === 1'b1) begin
      chk("hrdata", {40'h0, hrdata}, exp_q.pop_front());
      chk("hresp", {71'h0, hresp}, 72'h0);
    end else if (obs == 2'h2)
      chk("line_tx", {line_txc, line_txd}, exp_q.pop_front());
    else if (obs == 2'h3)
      chk("status", {67'h0, irq, unidirectional_en, link_fault_gen_en,
        remote_fault_status, local_fault_status}, exp_q.pop_front());
  end

  // Watchdog on the whole run
  initial begin
    repeat (100000) @(posedge hclk);
    err_count++;
    test_done;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, hi, obs, htrans} = '0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'h2;
    kind = 2'h3;
    txd = IDLE_COL;
    txc = IDLE_CTL;
    seed = 32'h9f79;
    err_count = 0;
    n_checks = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    st(5'h00);
    rd(CFG_IDX, 32'h0);
    rd(IEN_IDX, 32'h0);
    rd(IST_IDX, 32'h0);
    rd(12'h7ff, 32'h0);
    bus(1'b1, IEN_IDX, 32'h1);
    // A differing sequence restarts the count of like ones
    cols(2'h1, 3, 1'b0);
    cols(2'h2, 1, 1'b1);
    cols(2'h1, 3, 1'b1);
    rd(LIVE_IDX, 32'h0);
    cols(2'h1, 1, 1'b0);
    rd(LIVE_IDX, 32'h1);
    st(5'h11);
    rd(IST_IDX, 32'h1);
    bus(1'b1, ICLR_IDX, 32'h1);
    rd(IST_IDX, 32'h0);
    bus(1'b1, CFG_IDX, 32'h1);
    rd(CFG_IDX, 32'h1);
    st(5'h05);
    rtx(2'h1);
    // One column short of the clear span, then the deciding column
    cols(2'h0, 7, 1'b0);
    rd(LIVE_IDX, 32'h1);
    cols(2'h0, 1, 1'b0);
    rd(LIVE_IDX, 32'h0);
    rd(IST_IDX, 32'h4);
    cols(2'h2, 4, 1'b1);
    rd(LIVE_IDX, 32'h2);
    rtx(2'h2);
    bus(1'b1, CFG_IDX, 32'h0);
    rtx(2'h0);
    st(5'h02);
    bus(1'b1, CFG_IDX, 32'h3);
    rd(CFG_IDX, 32'h3);
    st(5'h0e);
    rtx(2'h0);
    cols(2'h1, 4, 1'b0);
    exp_q.push_back({RF_CTL, RF_COL});
    txd <= IDLE_COL;
    txc <= IDLE_CTL;
    @(posedge hclk) obs <= 2'h2;
    @(posedge hclk) obs <= 2'h0;
    rtx(2'h0);
    st(5'h1d);
    rd(IST_IDX, 32'hf);
    // Mid-run reset turns signalling off; idle tx keeps line checks quiet
    txd <= IDLE_COL;
    txc <= IDLE_CTL;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    st(5'h00);
    rd(IST_IDX, 32'h0);
    test_done;
  end
endmodule // tb_top
